// >>> rtl/msc_store.sv
/*
 meter status flags, parity-protected data words and the 56 paired
 shadow / antifuse configuration cells, reached over the serial link.
 assumes status conditions come from metering logic on clk_i, pins are
 sensed asynchronously, and the host holds a latched snapshot steady
 (no new latch) while a frame reads it out.
*/
`timescale 1ns/1ps
// Function
// - no-load at status bit 0, stuck modulator at bit 1.
// - frequency flag bit 2 set outside 45-65 Hz, clear inside.
// - tamper flag bit 3 follows tamper detection.
// - bit 4 shows chosen current channel, 0 primary, 1 secondary.
// - bit 5 is 0 on rising voltage, 1 on falling.
// - bit 6 set when a sensed output pin differs from driven value.
// - bit 7 set after reset, cleared once data words are valid.
// - all eight status flags readable over the serial link.
// - standalone: no-load on clock wire, tamper on data wire.
// - eight words of 4-bit parity plus 28-bit data value.
// - each parity bit is odd parity of seven same-position bits.
// - only mode bits and both configuration words are writable.
// - two configuration words give 56 cells plus eight parity bits.
// - permanent write programs an antifuse that only the factory blank clears after.
// - every shadow latch clears on any reset, remote reset included.
// - unprogrammed antifuses read as 0.
// - origin select 1 uses shadows unless the lock cell is programmed, 0 uses antifuses.
// - lock cell programmed: only precharge and remote reset accepted.
// - cell 1 picks 4 MHz or 8 MHz clock range.
// - cell 2 picks crystal or RC oscillator.
// - cells 3..4 select operating role, 2 and 3 standalone.
module msc_store
    import msc_pkg::*;
(
    // system
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic factory_blank_i,
    // status conditions from metering logic
    input wire logic no_load_det_i,
    input wire logic mod_stuck_det_i,
    input wire logic freq_out_of_band_i,
    input wire logic tamper_det_i,
    input wire logic chan_secondary_i,
    input wire logic volt_falling_i,
    input wire logic results_valid_i,
    input wire logic [MSC_NUM_PINS-1:0] pins_driven_i,
    input wire logic [MSC_NUM_PINS-1:0] pins_sensed_i,
    input wire logic [MSC_NUM_MEAS*MSC_DATA_W-1:0] meas_values_i,
    // serial link
    input wire logic serial_clock_wire_i,
    input wire logic link_select_n_i,
    input wire logic serial_data_wire_i,
    input wire logic serial_latch_wire_i,
    output logic serial_clock_wire_o,
    output logic serial_clock_wire_oe_o,
    output logic serial_data_wire_o,
    output logic serial_data_wire_oe_o,
    // configuration and status out
    output logic [MSC_NUM_CELLS-1:0] cfg_active_o,
    output logic clock_range_select_o,
    output logic oscillator_type_select_o,
    output logic [1:0] operating_role_select_o,
    output logic [7:0] meter_status_flags_o,
    output logic [7:0] mode_bits_o
);
    localparam int unsigned SNAP_W = MSC_NUM_WORDS * MSC_WORD_W;

    // sys domain state
    logic [7:0] status_q;
    logic [7:0] mode_q;
    logic [MSC_NUM_CELLS-1:0] shadow_q;
    logic [MSC_NUM_CELLS-1:0] afuse_q;
    logic [SNAP_W-1:0] snap_q;
    logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
    logic pin_diff_q;
    logic [2:0] tgl_sync_q;
    logic [2:0] ltch_sync_q;
    logic [7:0] cmd_sys_q;
    logic rreset_q;

    // link domain state
    logic [7:0] bit_cnt_q;
    logic [7:0] cmd_shift_q;
    logic [7:0] cmd_link_q;
    // level flag: high from the eighth link edge until the frame ends
    logic cmd_ready_q;
    logic dout_q;

    // pin check: a change counts once stages two and three agree
    wire logic pins_agree = (pin_s2_q == pin_s3_q);
    wire logic pins_mismatch = |(pin_s3_q ^ pins_driven_i);

    always_ff @(posedge clk_i) begin
        pin_s1_q <= pins_sensed_i;
        pin_s2_q <= pin_s1_q;
        pin_s3_q <= pin_s2_q;
    end

    // a pin still settling keeps the previous verdict
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_diff_q <= 1'b0;
        end else if (pins_agree) begin
            pin_diff_q <= pins_mismatch;
        end
    end

    // status register; invalid flag stays set until results are valid
    wire logic restart = sys_rst_i | rreset_q;
    wire logic [7:0] status_d = {
        ~results_valid_i & status_q[MSC_ST_INVALID],
        pin_diff_q,
        volt_falling_i,
        chan_secondary_i,
        tamper_det_i,
        freq_out_of_band_i,
        mod_stuck_det_i,
        no_load_det_i
    };

    always_ff @(posedge clk_i) begin
        if (restart) begin
            status_q <= MSC_STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // command crossing: ready level through three stages, byte held meanwhile;
    // a level cleared by frame select needs no reset in the link domain
    wire logic cmd_event = tgl_sync_q[1] & ~tgl_sync_q[2];
    wire logic latch_rise = ltch_sync_q[1] & ~ltch_sync_q[2];

    always_ff @(posedge clk_i) begin
        tgl_sync_q <= {tgl_sync_q[1:0], cmd_ready_q};
        ltch_sync_q <= {ltch_sync_q[1:0], serial_latch_wire_i};
        if (sys_rst_i) begin
            cmd_sys_q <= 8'h00;
        end else if (cmd_event) begin
            cmd_sys_q <= cmd_link_q;
        end
    end

    logic cmd_pending_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cmd_pending_q <= 1'b0;
        end else begin
            cmd_pending_q <= cmd_event;
        end
    end

    // command decode
    wire logic [1:0] cmd_op = cmd_sys_q[7:6];
    wire logic [5:0] cmd_addr = cmd_sys_q[5:0];
    wire logic locked = afuse_q[MSC_CELL_LOCK];
    wire logic addr_is_cell = (cmd_addr < MSC_MODE_BASE);
    wire logic [5:0] mode_idx = cmd_addr - MSC_MODE_BASE;
    wire logic do_rreset = cmd_pending_q & (cmd_op == MSC_OP_RRESET);
    wire logic do_shadow = cmd_pending_q & (cmd_op == MSC_OP_SHADOW) & ~locked;
    wire logic do_program = cmd_pending_q & (cmd_op == MSC_OP_PROGRAM) & ~locked;
    wire logic do_cell_set = do_shadow & addr_is_cell;
    wire logic do_mode_set = do_shadow & ~addr_is_cell;
    wire logic do_fuse = do_program & addr_is_cell;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rreset_q <= 1'b0;
        end else begin
            rreset_q <= do_rreset;
        end
    end

    // shadow latches and mode bits clear on either reset
    always_ff @(posedge clk_i) begin
        if (restart) begin
            shadow_q <= '0;
            mode_q <= MSC_MODE_RST;
        end else begin
            if (do_cell_set) begin
                shadow_q[cmd_addr] <= 1'b1;
            end
            if (do_mode_set) begin
                mode_q[mode_idx[2:0]] <= 1'b1;
            end
        end
    end

    // antifuses survive every reset; only the factory blank clears them
    always_ff @(posedge clk_i) begin
        if (factory_blank_i) begin
            afuse_q <= '0;
        end else if (do_fuse) begin
            afuse_q[cmd_addr] <= 1'b1;
        end
    end

    // source selection; a locked part can no longer run from shadows
    wire logic use_shadow = mode_q[MSC_MODE_ORIGIN] & ~locked;
    wire logic [MSC_NUM_CELLS-1:0] cfg_active = use_shadow ? shadow_q : afuse_q;

    assign cfg_active_o = cfg_active;
    assign clock_range_select_o = cfg_active[MSC_CELL_CLK];
    assign oscillator_type_select_o = cfg_active[MSC_CELL_OSC];
    assign operating_role_select_o = cfg_active[MSC_CELL_ROLE +: 2];
    assign meter_status_flags_o = status_q;
    assign mode_bits_o = mode_q;

    wire logic standalone = operating_role_select_o[1];

    // data values before parity; status and mode ride in the top field
    logic [MSC_DATA_W-1:0] word_val [MSC_NUM_WORDS];
    always_comb begin
        for (int w = 0; w < MSC_NUM_MEAS; w++) begin
            word_val[w] = meas_values_i[w*MSC_DATA_W +: MSC_DATA_W];
        end
        word_val[MSC_W_STATUS][MSC_FIELD_LSB +: 8] = status_q;
        word_val[MSC_W_FUND][MSC_FIELD_LSB +: 8] = mode_q;
        word_val[MSC_W_CFG_LO] = cfg_active[0 +: MSC_DATA_W];
        word_val[MSC_W_CFG_HI] = cfg_active[MSC_DATA_W +: MSC_DATA_W];
    end

    // one parity builder per word, fed live, so any readout is consistent
    logic [SNAP_W-1:0] words;
    for (genvar g = 0; g < MSC_NUM_WORDS; g++) begin : g_word
        msc_parity i_par (
            .value_i(word_val[g]),
            .word_o(words[g*MSC_WORD_W +: MSC_WORD_W])
        );
    end

    // snapshot on latch; host reads it in a later frame
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            snap_q <= '0;
        end else if (latch_rise) begin
            snap_q <= words;
        end
    end

    // link domain: frame select clears the bit counter between frames,
    // since the host's clock does not run outside frames
    always_ff @(posedge serial_clock_wire_i or posedge link_select_n_i) begin
        if (link_select_n_i) begin
            bit_cnt_q <= 8'h00;
            cmd_ready_q <= 1'b0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 8'h01;
            if (bit_cnt_q == MSC_BITCNT_CMD) begin
                cmd_ready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge serial_clock_wire_i) begin
        cmd_shift_q <= {cmd_shift_q[6:0], serial_data_wire_i};
        if (!link_select_n_i && bit_cnt_q == MSC_BITCNT_CMD) begin
            cmd_link_q <= {cmd_shift_q[6:0], serial_data_wire_i};
        end
        dout_q <= snap_q[~bit_cnt_q];
    end

    // pin roles: standalone drives flags out, peripheral talks on the link
    assign serial_clock_wire_o = status_q[MSC_ST_NO_LOAD];
    assign serial_clock_wire_oe_o = standalone;
    assign serial_data_wire_o = standalone ? status_q[MSC_ST_TAMPER] : dout_q;
    assign serial_data_wire_oe_o = standalone | ~link_select_n_i;
endmodule

// odd parity nibble over a 28-bit value, bit j over bits j, j+4 .. j+24
module msc_parity
    import msc_pkg::*;
(
    // data value in
    input wire logic [MSC_DATA_W-1:0] value_i,
    // parity nibble above the value
    output logic [MSC_WORD_W-1:0] word_o
);
    logic [MSC_PAR_W-1:0] par;

    always_comb begin
        par = {MSC_PAR_W{1'b1}};
        for (int k = 0; k < MSC_DATA_W; k++) begin
            par[k % MSC_PAR_W] = par[k % MSC_PAR_W] ^ value_i[k];
        end
    end

    assign word_o = {par, value_i};
endmodule

// >>> rtl/msc_pkg.sv
/*
 holds constants shared by the meter status and configuration store:
 flag positions, word indices, cell addresses, command codes, widths.
 assumes nothing of its surroundings.
*/
package msc_pkg;
    localparam int unsigned MSC_NUM_WORDS = 8;
    localparam int unsigned MSC_DATA_W = 28;
    localparam int unsigned MSC_PAR_W = 4;
    localparam int unsigned MSC_WORD_W = 32;
    localparam int unsigned MSC_NUM_CELLS = 56;
    localparam int unsigned MSC_NUM_MEAS = 6;
    localparam int unsigned MSC_NUM_PINS = 3;
    // status flag positions
    localparam int unsigned MSC_ST_NO_LOAD = 0;
    localparam int unsigned MSC_ST_MOD_STUCK = 1;
    localparam int unsigned MSC_ST_FREQ = 2;
    localparam int unsigned MSC_ST_TAMPER = 3;
    localparam int unsigned MSC_ST_CHAN = 4;
    localparam int unsigned MSC_ST_SLOPE = 5;
    localparam int unsigned MSC_ST_PINCHK = 6;
    localparam int unsigned MSC_ST_INVALID = 7;
    localparam logic [7:0] MSC_STATUS_RST = 8'h80;
    // word indices and field positions
    localparam int unsigned MSC_W_STATUS = 0;
    localparam int unsigned MSC_W_FUND = 1;
    localparam int unsigned MSC_W_CFG_LO = 6;
    localparam int unsigned MSC_W_CFG_HI = 7;
    localparam int unsigned MSC_FIELD_LSB = 20;
    // configuration cell addresses
    localparam int unsigned MSC_CELL_LOCK = 0;
    localparam int unsigned MSC_CELL_CLK = 1;
    localparam int unsigned MSC_CELL_OSC = 2;
    localparam int unsigned MSC_CELL_ROLE = 3;
    localparam logic [5:0] MSC_MODE_BASE = 6'h38;
    localparam int unsigned MSC_MODE_ORIGIN = 0;
    localparam logic [7:0] MSC_MODE_RST = 8'h00;
    // command byte: op in [7:6], address in [5:0]
    localparam logic [1:0] MSC_OP_PRECHARGE = 2'h0;
    localparam logic [1:0] MSC_OP_SHADOW = 2'h1;
    localparam logic [1:0] MSC_OP_PROGRAM = 2'h2;
    localparam logic [1:0] MSC_OP_RRESET = 2'h3;
    localparam logic [7:0] MSC_BITCNT_CMD = 8'h07;
endpackage

// >>> test/msc_store_assertions.sv
/* port checks for msc_store, bound to every instance.
 assumes all watched outputs live on clk_i. */
`timescale 1ns/1ps
module msc_store_assertions
    import msc_pkg::*;
(
    // system
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic factory_blank_i,
    // conditions and link
    input wire logic no_load_det_i,
    input wire logic mod_stuck_det_i,
    input wire logic freq_out_of_band_i,
    input wire logic tamper_det_i,
    input wire logic chan_secondary_i,
    input wire logic volt_falling_i,
    input wire logic results_valid_i,
    input wire logic link_select_n_i,
    // outputs
    input wire logic serial_clock_wire_o,
    input wire logic serial_clock_wire_oe_o,
    input wire logic serial_data_wire_o,
    input wire logic serial_data_wire_oe_o,
    input wire logic [MSC_NUM_CELLS-1:0] cfg_active_o,
    input wire logic clock_range_select_o,
    input wire logic oscillator_type_select_o,
    input wire logic [1:0] operating_role_select_o,
    input wire logic [7:0] meter_status_flags_o,
    input wire logic [7:0] mode_bits_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    wire logic [1:0] role = operating_role_select_o;
    wire logic [7:0] st = meter_status_flags_o;
    // pin outputs are registered, so only a settled role is judged
    sequence s_alone;
        role[1] && $stable({role, st[3], st[0]});
    endsequence
    sequence s_periph;
        !role[1] && $stable(role) && link_select_n_i;
    endsequence
    // a remote reset raises bit 7, which masks this check until results are valid again
    a_flag_follow: assert property (!$past(sys_rst_i) && !st[7] |-> st[5:0] ==
        $past({volt_falling_i, chan_secondary_i, tamper_det_i, freq_out_of_band_i,
        mod_stuck_det_i, no_load_det_i})) else $error("status flags lag their inputs");
    a_reset_state: assert property ($past(sys_rst_i) |-> st == 8'h80 && mode_bits_o == 8'h00)
        else $error("state after reset wrong");
    a_invalid_clear: assert property (!$past(sys_rst_i) && $past(results_valid_i) |-> !st[7])
        else $error("data invalid flag not cleared");
    a_range_field: assert property (clock_range_select_o == cfg_active_o[1])
        else $error("clock range not cell 1");
    a_osc_field: assert property (oscillator_type_select_o == cfg_active_o[2])
        else $error("oscillator type not cell 2");
    a_role_field: assert property (role == cfg_active_o[4:3])
        else $error("role not cells 3 to 4");
    a_standalone_pins: assert property (s_alone |-> serial_clock_wire_oe_o
        && serial_data_wire_oe_o && serial_clock_wire_o == st[0] && serial_data_wire_o == st[3])
        else $error("standalone pins wrong");
    a_periph_quiet: assert property (s_periph |-> !serial_clock_wire_oe_o
        && !serial_data_wire_oe_o) else $error("pins driven in peripheral role");
    a_locked_frozen: assert property (cfg_active_o[0] && !mode_bits_o[0] && !factory_blank_i
        |=> $stable(cfg_active_o)) else $error("locked configuration changed");
endmodule
bind msc_store msc_store_assertions i_chk (.*);

// >>> test/msc_host_model.sv
/* host side of the serial link: clock runs only inside frames,
 commands go out msb first, read bits are caught on the falling edge.
 the task spaces its own frames; 400 ns idle ends each one. */
`timescale 1ns/1ps
module msc_host_model (
    // link
    output logic sclk_o,
    output logic sel_n_o,
    output logic mosi_o,
    output logic latch_o,
    input wire logic miso_i
);
    initial begin
        sclk_o = 1'b0;
        sel_n_o = 1'b1;
        mosi_o = 1'b0;
        latch_o = 1'b0;
    end
    task automatic frame(input logic [7:0] cmd, input int n, output logic [255:0] rd);
        rd = '0;
        sel_n_o = 1'b0;
        #62.5;
        for (int k = 0; k < n; k++) begin
            mosi_o = (k < 8) ? cmd[7-k] : ~mosi_o;
            #62.5 sclk_o = 1'b1;
            #62.5 sclk_o = 1'b0;
            rd[255-k] = miso_i;
        end
        #62.5 sel_n_o = 1'b1;
        // a released line must not keep its last value
        mosi_o = ~mosi_o;
        #400;
    endtask
    task automatic read_all(output logic [255:0] rd);
        latch_o = 1'b1;
        #200 latch_o = 1'b0;
        #100 frame(8'h00, 256, rd);
    endtask
endmodule

// >>> test/tb.sv
/* self-checking bench for msc_store with the host model on the link.
 assumes the checker is bound by its own file. */
`timescale 1ns/1ps
module tb;
    import msc_pkg::*;
    logic clk_i, sys_rst_i, factory_blank_i, results_valid_i;
    logic [5:0] det;
    wire logic volt_falling_i, chan_secondary_i, tamper_det_i;
    wire logic freq_out_of_band_i, mod_stuck_det_i, no_load_det_i;
    logic [MSC_NUM_PINS-1:0] pins_driven_i, pins_sensed_i;
    logic [MSC_NUM_MEAS*MSC_DATA_W-1:0] meas_values_i;
    wire logic serial_clock_wire_i, link_select_n_i, serial_data_wire_i, serial_latch_wire_i;
    wire logic serial_clock_wire_o, serial_clock_wire_oe_o, serial_data_wire_o;
    wire logic serial_data_wire_oe_o, clock_range_select_o, oscillator_type_select_o;
    wire logic [MSC_NUM_CELLS-1:0] cfg_active_o;
    wire logic [1:0] operating_role_select_o;
    wire logic [7:0] meter_status_flags_o, mode_bits_o;
    logic [255:0] rd;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    assign {volt_falling_i, chan_secondary_i, tamper_det_i} = det[5:3];
    assign {freq_out_of_band_i, mod_stuck_det_i, no_load_det_i} = det[2:0];
    msc_store i_dut (.*);
    msc_host_model i_host (.sclk_o(serial_clock_wire_i), .sel_n_o(link_select_n_i),
        .mosi_o(serial_data_wire_i), .latch_o(serial_latch_wire_i),
        .miso_i(serial_data_wire_oe_o ? serial_data_wire_o : 1'bz));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [1:0] op, input logic [5:0] a);
        logic [255:0] d;
        i_host.frame({op, a}, 8, d);
        @(negedge clk_i);
    endtask
    function automatic logic [31:0] word(input logic [27:0] d);
        logic [3:0] p;
        for (int j = 0; j < 4; j++) begin
            p[j] = ~^{d[j], d[j+4], d[j+8], d[j+12], d[j+16], d[j+20], d[j+24]};
        end
        return {p, d};
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ceiling is about five times the expected run
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        sys_rst_i = 1'b1;
        factory_blank_i = 1'b1;
        results_valid_i = 1'b0;
        det = '0;
        pins_driven_i = '0;
        pins_sensed_i = '0;
        meas_values_i = {28'h0F0F0F0, 28'h1234567, 28'hABCDEF1, 28'h5555555, 28'h7654321,
            28'h89ABCDE};
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        factory_blank_i = 1'b0;
        @(negedge clk_i);
        chk({mode_bits_o, meter_status_flags_o}, 16'h0080);
        chk(cfg_active_o, '0);
        for (int i = 0; i < 6; i++) begin
            det = 6'h01 << i;
            repeat (2) @(negedge clk_i);
            chk(meter_status_flags_o, {2'h2, det});
        end
        det = '0;
        results_valid_i = 1'b1;
        pins_driven_i = 3'h5;
        @(negedge clk_i);
        results_valid_i = 1'b0;
        repeat (8) @(negedge clk_i);
        chk(meter_status_flags_o, 8'h40);
        pins_sensed_i = 3'h5;
        repeat (8) @(negedge clk_i);
        chk(meter_status_flags_o, 8'h00);
        i_host.read_all(rd);
        chk(rd[31:0], word({8'h00, meas_values_i[19:0]}));
        chk(rd[95:64], word(meas_values_i[56+:28]));
        cmd(MSC_OP_SHADOW, 6'd1);
        chk(cfg_active_o, '0);
        cmd(MSC_OP_SHADOW, MSC_MODE_BASE);
        chk({mode_bits_o, oscillator_type_select_o, clock_range_select_o}, 10'h005);
        cmd(MSC_OP_SHADOW, 6'd2);
        cmd(MSC_OP_SHADOW, 6'd4);
        chk({operating_role_select_o, oscillator_type_select_o}, 3'h5);
        det = 6'h09;
        repeat (4) @(negedge clk_i);
        chk({serial_clock_wire_o, serial_data_wire_o}, 2'h3);
        det = '0;
        // a system reset leaves the standalone role before the link is used again
        sys_rst_i = 1'b1;
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        cmd(MSC_OP_SHADOW, MSC_MODE_BASE);
        chk(cfg_active_o, '0);
        cmd(MSC_OP_RRESET, 6'd0);
        chk({mode_bits_o, meter_status_flags_o}, 16'h0080);
        cmd(MSC_OP_PROGRAM, 6'd2);
        chk(cfg_active_o, 56'h4);
        cmd(MSC_OP_PROGRAM, 6'd60);
        cmd(MSC_OP_PROGRAM, 6'd0);
        cmd(MSC_OP_SHADOW, 6'd1);
        cmd(MSC_OP_SHADOW, MSC_MODE_BASE);
        cmd(MSC_OP_PROGRAM, 6'd3);
        chk({mode_bits_o, cfg_active_o}, 64'h5);
        i_host.read_all(rd);
        chk(rd[255:192], {word(28'h0), word(28'h5)});
        report_and_stop();
    end
endmodule
